// ==== drp_consts.svh ====
// constants for the descriptor RAM slave port
// assumes a byte-addressed 16-bit offset space on one core clock
// What this block does
// - raise write response valid only after the write is done and response valid
// - hold write response valid and its code until the master takes it
// - the 3-bit read protection input has no effect on reads
// - offer read address ready when free; capture address on the handshake
// - return the 32-bit word stored at the captured address
// - read response codes: 00 okay inside the RAM, 11 decode error outside it; 01 and 10 are never returned
// - read valid once data is present, held until the master takes it
// - reset leaves the RAM contents untouched; software clears entries by writing
// - the RAM occupies offsets 0x0000 up to 0x1000 on this port
`ifndef DRP_CONSTS_SVH
`define DRP_CONSTS_SVH
`define DRP_ADDR_W     16
`define DRP_DATA_W     32
`define DRP_RAM_BASE   16'h0000
`define DRP_RAM_LIMIT  16'h1000
`define DRP_RAM_DEPTH  1024
`define DRP_RESP_OKAY  2'h0
`define DRP_RESP_EXOK  2'h1
`define DRP_RESP_SLVE  2'h2
`define DRP_RESP_DECE  2'h3
`endif

// ==== drp_pkg.sv ====
// types for the descriptor RAM slave port
// assumes drp_consts.svh supplies the numeric constants
`default_nettype none
package drp_pkg;
	typedef enum logic [1:0] {
		DRP_IDLE,
		DRP_FETCH,
		DRP_RESP
	} drp_rd_state_e;
	typedef logic [1:0] drp_resp_t;
endpackage
`default_nettype wire

// ==== drp_desc_ram_port.sv ====
// descriptor RAM with its AXI4-Lite read channels and write response channel
// assumes the write address/data channels are merged upstream into one
// write strobe on the same clock; the master follows AXI4-Lite handshakes
// assumes only explicit writes ever change a descriptor
`timescale 1ns/1ps
`default_nettype none
`include "drp_consts.svh"
module drp_desc_ram_port #(
	parameter int DEPTH = `DRP_RAM_DEPTH
) (
	// clock and reset
	input  wire logic                    i_clk,
	input  wire logic                    i_reset_n,
	// merged write request from the write address/data channels
	input  wire logic                    i_wr_valid,
	input  wire logic [`DRP_ADDR_W-1:0]  i_wr_addr,
	input  wire logic [`DRP_DATA_W-1:0]  i_wr_data,
	input  wire logic [3:0]              i_wr_strb,
	output logic                         o_wr_ready,
	// write response channel
	output logic                         o_bvalid,
	output logic [1:0]                   o_bresp,
	input  wire logic                    i_bready,
	// read address channel
	input  wire logic [`DRP_ADDR_W-1:0]  i_araddr,
	input  wire logic [2:0]              i_arprot,
	input  wire logic                    i_arvalid,
	output logic                         o_arready,
	// read data channel
	output logic [`DRP_DATA_W-1:0]       o_rdata,
	output logic [1:0]                   o_rresp,
	output logic                         o_rvalid,
	input  wire logic                    i_rready
);
	localparam int IDX_W = $clog2(DEPTH);

	// one word per descriptor slot, indexed by the offset bits above the lanes
	logic [`DRP_DATA_W-1:0]  mem [DEPTH];
	drp_pkg::drp_rd_state_e  state;
	drp_pkg::drp_rd_state_e  next_state;
	logic [`DRP_ADDR_W-1:0]  rd_addr;
	logic [`DRP_ADDR_W-1:0]  next_rd_addr;
	logic [`DRP_DATA_W-1:0]  next_rdata;
	drp_pkg::drp_resp_t      next_rresp;
	logic                    next_bvalid;
	drp_pkg::drp_resp_t      next_bresp;
	logic                    wr_fire;
	logic                    wr_hit;
	logic                    ar_fire;
	logic                    rd_hit;
	logic [IDX_W-1:0]        wr_idx;
	logic [IDX_W-1:0]        rd_idx;
	logic [`DRP_DATA_W-1:0]  next_word;
	logic                    ram_we;

	// protection bits deliberately unread
	assign wr_idx  = i_wr_addr[IDX_W+1:2];
	assign rd_idx  = rd_addr[IDX_W+1:2];
	assign wr_hit  = i_wr_addr < `DRP_RAM_LIMIT;
	assign rd_hit  = rd_addr < `DRP_RAM_LIMIT;
	// a pending response stalls the next write rather than losing it
	assign o_wr_ready = !o_bvalid;
	assign wr_fire    = i_wr_valid && o_wr_ready;
	// one read in flight keeps this small; at best one word every three cycles
	assign o_arready  = state == drp_pkg::DRP_IDLE;
	assign ar_fire    = i_arvalid && o_arready;

	// byte lanes merged into the old word, so one full-word write per edge
	always_comb begin
		ram_we    = wr_fire && wr_hit;
		next_word = mem[wr_idx];
		for (int b = 0; b < 4; b++) begin
			if (i_wr_strb[b]) begin
				next_word[b*8 +: 8] = i_wr_data[b*8 +: 8];
			end
		end
	end

	// no reset here: descriptors survive a core reset
	always_ff @(posedge i_clk) begin
		if (ram_we) begin
			mem[wr_idx] <= next_word;
		end
	end

	// write response
	always_comb begin
		next_bvalid = o_bvalid;
		next_bresp  = o_bresp;
		if (o_bvalid && i_bready) begin
			next_bvalid = 1'b0;
		end
		// the RAM word is written on the same edge that raises the response
		if (wr_fire) begin
			next_bvalid = 1'b1;
			next_bresp  = wr_hit ? `DRP_RESP_OKAY : `DRP_RESP_DECE;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			o_bvalid <= 1'b0;
			o_bresp  <= `DRP_RESP_OKAY;
		end else begin
			o_bvalid <= next_bvalid;
			o_bresp  <= next_bresp;
		end
	end

	// read path: accept, fetch one cycle, then hold the answer
	always_comb begin
		next_state   = state;
		next_rd_addr = rd_addr;
		next_rdata   = o_rdata;
		next_rresp   = o_rresp;
		unique case (state)
			drp_pkg::DRP_IDLE: begin
				if (ar_fire) begin
					next_rd_addr = i_araddr;
					next_state   = drp_pkg::DRP_FETCH;
				end
			end
			drp_pkg::DRP_FETCH: begin
				// out-of-range reads answer zero so stale data never leaks
				next_rdata = rd_hit ? mem[rd_idx] : '0;
				next_rresp = rd_hit ? `DRP_RESP_OKAY : `DRP_RESP_DECE;
				next_state = drp_pkg::DRP_RESP;
			end
			drp_pkg::DRP_RESP: begin
				// waiting here is what keeps the address channel closed
				if (i_rready) begin
					next_state = drp_pkg::DRP_IDLE;
				end
			end
			default: next_state = drp_pkg::DRP_IDLE;
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			state   <= drp_pkg::DRP_IDLE;
			rd_addr <= '0;
			o_rdata <= '0;
			o_rresp <= `DRP_RESP_OKAY;
		end else begin
			state   <= next_state;
			rd_addr <= next_rd_addr;
			o_rdata <= next_rdata;
			o_rresp <= next_rresp;
		end
	end

	// valid comes straight from state so it can never lag the data
	assign o_rvalid = state == drp_pkg::DRP_RESP;

	// write response channel and RAM write
	a_bvalid_cause: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		$rose(o_bvalid) |-> $past(wr_fire))
		else $error("write response raised without a write");

	a_bvalid_hold: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
		else $error("write response dropped before taken");

	a_bvalid_idle: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		!o_bvalid && !wr_fire |=> !o_bvalid)
		else $error("write response raised with no write taken");

	a_bvalid_release: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		o_bvalid && i_bready |=> !o_bvalid)
		else $error("write response still valid after it was taken");

	a_bresp_code: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		wr_fire |=> o_bvalid && o_bresp == (($past(i_wr_addr) < `DRP_RAM_LIMIT) ? `DRP_RESP_OKAY : `DRP_RESP_DECE))
		else $error("write response code wrong for address");

	a_ram_write: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		wr_fire && wr_hit && i_wr_strb == 4'hF |=> mem[$past(wr_idx)] == $past(i_wr_data))
		else $error("full-word write did not reach the RAM");

	// read channels
	a_ar_capture: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		ar_fire |=> rd_addr == $past(i_araddr) && !o_arready)
		else $error("read address not captured");

	a_read_latency: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		ar_fire |-> ##2 o_rvalid)
		else $error("read data not valid two cycles after address");

	a_rvalid_early: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		ar_fire |=> !o_rvalid)
		else $error("read data valid before the fetch");

	a_rvalid_hold: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata) && $stable(o_rresp))
		else $error("read data changed before taken");

	a_read_data: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		$rose(o_rvalid) && rd_hit && !$past(wr_fire) |-> o_rdata == mem[rd_idx])
		else $error("read data differs from RAM word");

	a_resp_decode: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		ar_fire |-> ##2 o_rresp == ((($past(i_araddr, 2)) < `DRP_RAM_LIMIT) ? `DRP_RESP_OKAY : `DRP_RESP_DECE))
		else $error("read response code wrong for address");

	a_rdata_decode: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		o_rvalid && o_rresp == `DRP_RESP_DECE |-> o_rdata == '0)
		else $error("decode error read returned nonzero data");

	a_one_read: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		o_rvalid && i_rready |=> !o_rvalid && o_arready)
		else $error("read channel not released after transfer");

	a_ar_busy: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		!o_arready && !(o_rvalid && i_rready) |=> !o_arready)
		else $error("address channel reopened before read data was taken");

	// reset idles both channels but leaves the RAM alone
	a_reset_idle: assert property (@(posedge i_clk)
		!i_reset_n |=> !o_bvalid && !o_rvalid && o_arready && o_wr_ready)
		else $error("channels not idle after reset");
endmodule // drp_desc_ram_port
`default_nettype wire

// ==== drp_master_model.sv ====
// master model for the descriptor RAM port
// assumes one core clock; requests change on the falling edge
`timescale 1ns/1ps
`default_nettype none
module drp_master_model (
	// clock and stall pattern
	input  wire logic        i_clk,
	input  wire logic [1:0]  i_rdy,
	// requests
	output logic             o_wr_valid,
	output logic [15:0]      o_wr_addr,
	output logic [31:0]      o_wr_data,
	output logic [3:0]       o_wr_strb,
	output logic             o_bready,
	output logic [15:0]      o_araddr,
	output logic [2:0]       o_arprot,
	output logic             o_arvalid,
	output logic             o_rready,
	// answers
	input  wire logic        i_wr_ready,
	input  wire logic        i_arready
);
	assign o_bready = i_rdy[0];
	assign o_rready = i_rdy[1];
	initial {o_wr_valid, o_wr_addr, o_wr_data, o_wr_strb, o_araddr, o_arprot, o_arvalid} = '0;
	task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s);
		@(negedge i_clk);
		{o_wr_addr, o_wr_data, o_wr_strb, o_wr_valid} = {a, d, s, 1'b1};
		do @(posedge i_clk); while (i_wr_ready !== 1'b1);
		@(negedge i_clk);
		o_wr_valid = 1'b0;
		// released lines flip so stale values are never trusted
		{o_wr_addr, o_wr_data} = ~{a, d};
	endtask
	task automatic rd(input logic [15:0] a, input logic [2:0] p);
		@(negedge i_clk);
		{o_araddr, o_arprot, o_arvalid} = {a, p, 1'b1};
		do @(posedge i_clk); while (i_arready !== 1'b1);
		@(negedge i_clk);
		o_arvalid = 1'b0;
		o_araddr = ~a;
	endtask
endmodule // drp_master_model
`default_nettype wire

// ==== test_drp_desc_ram_port.sv ====
// self-checking bench for the descriptor RAM port
// assumes the master model paces every request
`timescale 1ns/1ps
`default_nettype none
module test_drp_desc_ram_port;
	logic        clk = 1'b0, reset_n = 1'b0, wv, wrdy, bv, br, arv, ardy, rv, rr;
	logic [1:0]  rdy = 2'h3, bresp, rresp;
	logic [2:0]  ap;
	logic [3:0]  ws;
	logic [15:0] wa, ara;
	logic [31:0] wd, rdata, x = 32'h7850, y = 32'h7850;
	logic [31:0] mem [0:1023];
	logic [33:0] rq [$];
	logic [1:0]  bq [$];
	int          n_fail = 0, cmp_count = 0, cyc = 0;
	always #25 clk = ~clk;
	function automatic logic [31:0] xs(input logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		return v ^ (v << 5);
	endfunction
	drp_desc_ram_port u_drp_desc_ram_port (.i_clk(clk), .i_reset_n(reset_n), .i_wr_valid(wv), .i_wr_addr(wa),
		.i_wr_data(wd), .i_wr_strb(ws), .o_wr_ready(wrdy), .o_bvalid(bv), .o_bresp(bresp), .i_bready(br),
		.i_araddr(ara), .i_arprot(ap), .i_arvalid(arv), .o_arready(ardy), .o_rdata(rdata), .o_rresp(rresp),
		.o_rvalid(rv), .i_rready(rr));
	drp_master_model u_drp_master_model (.i_clk(clk), .i_rdy(rdy), .o_wr_valid(wv), .o_wr_addr(wa),
		.o_wr_data(wd), .o_wr_strb(ws), .o_bready(br), .o_araddr(ara), .o_arprot(ap), .o_arvalid(arv),
		.o_rready(rr), .i_wr_ready(wrdy), .i_arready(ardy));
	task automatic end_sim();
		$display("mismatches %0d compares %0d", n_fail, cmp_count);
		if (n_fail == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk_b(input logic [1:0] e, input logic [1:0] g);
		cmp_count++;
		if (g !== e) begin
			n_fail++;
			$display("CHECK FAILED %0t bresp %h want %h", $time, g, e);
		end
	endtask
	task automatic chk_r(input logic [33:0] e, input logic [33:0] g);
		cmp_count++;
		if (g !== e) begin
			n_fail++;
			$display("CHECK FAILED %0t read %h want %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [3:0] s);
		x = xs(x);
		for (int i = 0; i < 4; i++)
			if (s[i] && a < 16'h1000) mem[a[11:2]][8*i+:8] = x[8*i+:8];
		bq.push_back(a < 16'h1000 ? 2'h0 : 2'h3);
		u_drp_master_model.wr(a, x, s);
	endtask
	// low address bits and protection are random: neither may matter
	task automatic rdc(input logic [15:0] a);
		x = xs(x);
		a[1:0] = x[1:0];
		rq.push_back(a < 16'h1000 ? {2'h0, mem[a[11:2]]} : {2'h3, 32'h0});
		u_drp_master_model.rd(a, x[4:2]);
	endtask
	task automatic rd_all();
		for (int i = 0; i < 8; i++) rdc(16'(i * 4));
		rdc(16'h0FFC);
		rdc(16'h1000);
		rdc(16'hFFFC);
		while (rq.size() != 0 || bq.size() != 0) @(posedge clk);
	endtask
	always @(negedge clk) begin
		y = xs(y);
		rdy <= y[1:0];
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc > 20000) begin
			n_fail++;
			end_sim();
		end else begin
			// an answer with nothing expected compares against unknown and fails
			if (bv === 1'b1 && br === 1'b1)
				chk_b(bq.size() > 0 ? bq.pop_front() : 2'hX, bresp);
			if (rv === 1'b1 && rr === 1'b1)
				chk_r(rq.size() > 0 ? rq.pop_front() : 34'hX, {rresp, rdata});
		end
	end
	initial begin
		repeat (8) @(negedge clk);
		reset_n = 1'b1;
		for (int i = 0; i < 8; i++) wr(16'(i * 4), 4'hF);
		wr(16'h0FFC, 4'hF);
		for (int i = 0; i < 24; i++) wr(16'(x[4:2] * 4), x[11:8]);
		wr(16'h1000, 4'hF);
		wr(16'hFFFC, 4'hF);
		rd_all();
		@(negedge clk);
		reset_n = 1'b0;
		repeat (2) @(negedge clk);
		reset_n = 1'b1;
		rd_all();
		end_sim();
	end
endmodule // test_drp_desc_ram_port
`default_nettype wire
